// [hw/fpdm_pkg.sv]
// Package with types and constants for the fan drive and speed meter.
`default_nettype none
package fpdm_pkg;
    // ========================================================
    // Sizes
    // ========================================================
    // Drive outputs and speed-pulse inputs.
    localparam int NUM_DRIVE = 4;
    localparam int NUM_SPEED = 8;
    // Period counter width and full-scale value.
    localparam int CNT_W = 16;
    localparam logic [15:0] CNT_FULL = 16'hffff;
    // Duty cycle resolution in bits.
    localparam int DUTY_W = 8;
    // ========================================================
    // Timing
    // ========================================================
    // Clock rate in Hz.
    localparam int CLK_HZ = 10_000_000;
    // Meter time base in Hz and the cycle count of one tick.
    localparam int METER_HZ = 90_000;
    localparam int METER_DIV = CLK_HZ / METER_HZ;
    // High rate drive frequency in Hz.
    localparam int HIGH_RATE_HZ = 22_500;
    // Low rate drive frequency default in Hz.
    localparam int LOW_RATE_HZ = 88;
    // Duty steps advance by a fractional accumulator, because one step of
    // the high rate is not a whole number of clock cycles. Rates are
    // scaled down by a common factor so the accumulator stays in 20 bits.
    localparam int RATE_SCALE = 64;
    localparam int STEP_MOD = CLK_HZ / RATE_SCALE;
    localparam int HIGH_INC = HIGH_RATE_HZ * 256 / RATE_SCALE;
    localparam int LOW_INC = LOW_RATE_HZ * 256 / RATE_SCALE;
    // Rising edges that close one window: first to third pulse.
    localparam logic [1:0] EDGES_PER_WIN = 2'h2;
    // ========================================================
    // Types
    // ========================================================
    // Per channel measurement phase.
    typedef enum logic [1:0] {
        FPDM_WAIT_FIRST,
        FPDM_COUNTING,
        FPDM_IDLE
    } fpdm_phase_t;
    // One speed channel.
    typedef struct packed {
        fpdm_phase_t phase;
        logic [1:0] edges;
        logic [15:0] count;
        logic [15:0] value;
        logic sync_a;
        logic sync_b;
        logic prev;
        logic fresh;
    } fpdm_chan_t;
    // Whole block state.
    typedef struct packed {
        logic [19:0] tick_cnt;
        logic [19:0] step_cnt;
        logic [7:0] phase_cnt;
        logic [3:0] drive;
        fpdm_chan_t [7:0] chan;
    } fpdm_state_t;
endpackage
`default_nettype wire

// [hw/fpdm_fan_pwm_drive_speed_meter.sv]
// Fan duty-cycle drive and speed-pulse period meter.
`default_nettype none
// Contract
// - Fan speed set by drive duty cycle.
// - Four drive outputs, eight speed inputs.
// - Low rate drive synced to its inputs.
// - High rate inputs always valid, unbroken drive.
// - Stretch drive on during three-wire measurement.
// - No stretching for steady drive or four-wire.
// - Count 90 kHz ticks into 16 bits.
// - Continuous bit removes stretching per input.
// - High rate forces continuous bit on.
// - Count first to third rising edge.
// - All ones means stalled or very slow.
// - Drive n pairs with inputs n, n+4.
// - High rate frequency fixed at 22.5 kHz.
module fpdm_fan_pwm_drive_speed_meter #(
    parameter int NUM_DRIVE = fpdm_pkg::NUM_DRIVE,
    parameter int NUM_SPEED = fpdm_pkg::NUM_SPEED
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // Configuration from the control logic.
    input wire logic high_rate_drive_i,
    input wire logic [7:0] continuous_measure_enable_i,
    input wire logic [31:0] duty_i,
    input wire logic measure_req_i,
    // Fan pins.
    input wire logic [7:0] fan_speed_pulse_input_i,
    output logic [3:0] fan_drive_o,
    // Measurement results.
    output logic [127:0] speed_value_o,
    output logic [7:0] speed_update_o,
    output logic [7:0] continuous_measure_o,
    output logic [7:0] stalled_o
);
    // ========================================================
    // State
    // ========================================================
    // Registered state and its next value.
    fpdm_pkg::fpdm_state_t state_q;
    fpdm_pkg::fpdm_state_t state_d;
    // Effective continuous bits after the high rate override.
    logic [7:0] cont_eff;
    // Drives held fully on because a paired input is measuring.
    logic [3:0] stretch;
    // Meter tick and duty step strobes.
    logic tick;
    logic step;
    // Accumulator increment of the selected rate and the summed value.
    logic [19:0] step_inc;
    logic [19:0] step_sum;

    // A rising edge is the second stage high while the stage after it
    // still holds the low level of the previous cycle.
    function automatic logic rise_seen(input fpdm_pkg::fpdm_chan_t ch);
        return ch.sync_b && !ch.prev;
    endfunction

    // Continuous bit is forced whenever high rate drive is on.
    assign cont_eff = continuous_measure_enable_i |
                      {8{high_rate_drive_i}};

    // A drive stretches while either paired input is still measuring
    // and is not in continuous mode.
    always_comb begin
        stretch = '0;
        for (int n = 0; n < NUM_DRIVE; n++) begin
            stretch[n] = (!cont_eff[n] &&
                          state_q.chan[n].phase != fpdm_pkg::FPDM_IDLE) ||
                         (!cont_eff[n + NUM_DRIVE] &&
                          state_q.chan[n + NUM_DRIVE].phase !=
                          fpdm_pkg::FPDM_IDLE);
        end
    end

    // The meter tick divides the clock by a whole number of cycles.
    // The resulting rate is a little above the nominal one, an error of
    // about one part in a thousand that no reading can resolve anyway.
    assign tick = state_q.tick_cnt ==
                  20'(fpdm_pkg::METER_DIV - 1);
    // The high rate increment is a fixed constant: software cannot move
    // it. A whole-cycle divider would round 444.4 cycles a period to a
    // different rate, so the step strobe comes from an accumulator that
    // carries the fraction forward and keeps the average rate exact.
    assign step_inc = high_rate_drive_i ? 20'(fpdm_pkg::HIGH_INC) :
                      20'(fpdm_pkg::LOW_INC);
    assign step_sum = state_q.step_cnt + step_inc;
    assign step = step_sum >= 20'(fpdm_pkg::STEP_MOD);

    // ========================================================
    // Next state
    // ========================================================
    // Each speed channel walks idle, wait for first edge, counting and
    // back to idle. A channel in continuous mode leaves idle on the very
    // next cycle, so results follow one another with one idle cycle
    // between them. A channel that is not continuous waits in idle for
    // a measure request and, while it measures, holds its drive fully
    // on so that the fan keeps turning and its pulses are not chopped.
    // A request that arrives while a channel is busy is ignored by that
    // channel; software sees the result through the update pulse.
    // The full-scale timeout is long: 65535 meter ticks, close to three
    // quarters of a second, during which a stretched drive stays on.
    // Both the wait for the first edge and the count between edges are
    // timed, so a rotor that never turns still ends with a reading.
    // One combinational pass computes the divider, drive and meters.
    always_comb begin
        state_d = state_q;
        state_d.tick_cnt = tick ? 20'h0 : state_q.tick_cnt + 20'h1;
        state_d.step_cnt = step ? step_sum - 20'(fpdm_pkg::STEP_MOD) :
                           step_sum;
        if (step) begin
            state_d.phase_cnt = state_q.phase_cnt + 8'h1;
        end
        // Duty compare; a stretched drive stays fully on.
        for (int n = 0; n < NUM_DRIVE; n++) begin
            state_d.drive[n] = stretch[n] ||
                (state_q.phase_cnt < duty_i[n*8 +: 8]);
        end
        for (int c = 0; c < NUM_SPEED; c++) begin
            // Two-stage synchroniser, edge found on the second stage.
            state_d.chan[c].sync_a = fan_speed_pulse_input_i[c];
            state_d.chan[c].sync_b = state_q.chan[c].sync_a;
            state_d.chan[c].prev = state_q.chan[c].sync_b;
            state_d.chan[c].fresh = 1'b0;
            case (state_q.chan[c].phase)
                fpdm_pkg::FPDM_IDLE: begin
                    // Continuous inputs restart at once; others wait.
                    if (cont_eff[c] || measure_req_i) begin
                        state_d.chan[c].phase = fpdm_pkg::FPDM_WAIT_FIRST;
                        // The wait for the first edge is timed as well.
                        state_d.chan[c].count = 16'h0;
                    end
                end
                fpdm_pkg::FPDM_WAIT_FIRST: begin
                    if (rise_seen(state_q.chan[c])) begin
                        state_d.chan[c].phase = fpdm_pkg::FPDM_COUNTING;
                        state_d.chan[c].count = 16'h0;
                        state_d.chan[c].edges = 2'h0;
                    end else if (state_q.chan[c].count ==
                                 fpdm_pkg::CNT_FULL) begin
                        // A rotor that never turns gives no first edge;
                        // without this timeout it would never report.
                        state_d.chan[c].value = fpdm_pkg::CNT_FULL;
                        state_d.chan[c].fresh = 1'b1;
                        state_d.chan[c].phase = fpdm_pkg::FPDM_IDLE;
                    end else if (tick) begin
                        state_d.chan[c].count =
                            state_q.chan[c].count + 16'h1;
                    end
                end
                fpdm_pkg::FPDM_COUNTING: begin
                    // Saturate rather than wrap, so a stall reads full.
                    if (tick && state_q.chan[c].count !=
                        fpdm_pkg::CNT_FULL) begin
                        state_d.chan[c].count =
                            state_q.chan[c].count + 16'h1;
                    end
                    if (rise_seen(state_q.chan[c])) begin
                        state_d.chan[c].edges = state_q.chan[c].edges + 2'h1;
                        if (state_q.chan[c].edges + 2'h1 ==
                            fpdm_pkg::EDGES_PER_WIN) begin
                            state_d.chan[c].value = state_d.chan[c].count;
                            state_d.chan[c].fresh = 1'b1;
                            state_d.chan[c].phase = fpdm_pkg::FPDM_IDLE;
                        end
                    end else if (state_q.chan[c].count ==
                                 fpdm_pkg::CNT_FULL) begin
                        // No third edge before full scale: report stall.
                        state_d.chan[c].value = fpdm_pkg::CNT_FULL;
                        state_d.chan[c].fresh = 1'b1;
                        state_d.chan[c].phase = fpdm_pkg::FPDM_IDLE;
                    end
                end
                default: begin
                    state_d.chan[c].phase = fpdm_pkg::FPDM_IDLE;
                end
            endcase
        end
    end

    // ========================================================
    // Registers
    // ========================================================
    // Synchronous reset leaves all channels idle with zero results.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_q <= '0;
            for (int c = 0; c < NUM_SPEED; c++) begin
                state_q.chan[c].phase <= fpdm_pkg::FPDM_IDLE;
                // Synchroniser stages start at the pulled-up idle level,
                // so a line that is high at release gives no false edge.
                state_q.chan[c].sync_a <= 1'b1;
                state_q.chan[c].sync_b <= 1'b1;
                state_q.chan[c].prev <= 1'b1;
            end
        end else begin
            state_q <= state_d;
        end
    end

    // ========================================================
    // Outputs
    // ========================================================
    // Value and update come straight from flip-flops; the stall flag is decoded from the stored value.
    always_comb begin
        // Defaults cover any lanes above the channel count.
        speed_value_o = '0;
        speed_update_o = '0;
        stalled_o = '0;
        for (int c = 0; c < NUM_SPEED; c++) begin
            speed_value_o[c*16 +: 16] = state_q.chan[c].value;
            speed_update_o[c] = state_q.chan[c].fresh;
            stalled_o[c] = state_q.chan[c].value ==
                           fpdm_pkg::CNT_FULL;
        end
    end
    assign fan_drive_o = state_q.drive;
    // The effective continuous bits are shown as they are decided, with
    // no register, so software sees the forced state in the same cycle.
    assign continuous_measure_o = cont_eff;
endmodule
`default_nettype wire

// [tb/fpdm_props.sv]
// Checker for the fan drive and speed meter ports.
`default_nettype none
module fpdm_props (
    // Clock, reset and configuration.
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic high_rate_drive_i,
    input wire logic [7:0] continuous_measure_enable_i,
    input wire logic [31:0] duty_i,
    // Fan pins and results.
    input wire logic [7:0] fan_speed_pulse_input_i,
    input wire logic [3:0] fan_drive_o,
    input wire logic [127:0] speed_value_o,
    input wire logic [7:0] speed_update_o,
    input wire logic [7:0] continuous_measure_o,
    input wire logic [7:0] stalled_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    // ========================================================
    // Helpers
    // ========================================================
    // Pin history; a result must follow a real rising edge.
    logic [7:0] hist_q;
    always_ff @(posedge ref_clk_i) begin
        hist_q <= {hist_q[6:0], fan_speed_pulse_input_i[0]};
    end
    // Zero duty with both paired inputs measuring continuously.
    sequence s_quiet0;
        duty_i[7:0] == 8'h00 && continuous_measure_o[0] &&
            continuous_measure_o[4];
    endsequence
    // ========================================================
    // Assertions
    // ========================================================
    chk_update_one_cycle: assert property (
        speed_update_o[0] |=> !speed_update_o[0])
        else $error("update pulse too long");
    chk_stall_flag: assert property (
        stalled_o[0] == (speed_value_o[15:0] == 16'hffff))
        else $error("stall flag wrong");
    chk_high_forces_cont: assert property (
        high_rate_drive_i |-> continuous_measure_o == 8'hff)
        else $error("continuous bits not forced");
    chk_cont_follow: assert property (
        !high_rate_drive_i |->
            continuous_measure_o == continuous_measure_enable_i)
        else $error("continuous bits wrong");
    chk_reset_quiet: assert property (disable iff (1'b0)
        srst_i |=> fan_drive_o == 4'h0 && speed_update_o == 8'h00)
        else $error("outputs active after reset");
    chk_value_hold: assert property (
        // Reset clears the value with no update pulse: skip that cycle.
        !speed_update_o[0] && !$past(srst_i) |->
            $stable(speed_value_o[15:0]))
        else $error("value changed without update");
    chk_zero_duty: assert property (
        s_quiet0 ##1 s_quiet0 |-> !fan_drive_o[0])
        else $error("drive on at zero duty");
    chk_update_edge: assert property (
        speed_update_o[0] && !stalled_o[0] |->
            |(hist_q[6:0] & ~hist_q[7:1]))
        else $error("result without pulse edge");
endmodule
`default_nettype wire

// [tb/fpdm_fan_model.sv]
// Fan model: speed pulses from a fan; a three-wire fan spins only while powered.
`default_nettype none
module fpdm_fan_model #(
    parameter int HALF = 555
) (
    // Clock, fan power and fan kind.
    input wire logic clk_i,
    input wire logic power_i,
    input wire logic three_wire_i,
    // Open-collector speed line seen through its pull-up.
    output logic pulse_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Half period counter and line level.
    int cnt = 0;
    logic lvl = 1'b0;
    // The rotor stops when an unpowered three-wire fan loses supply.
    always @(posedge clk_i) begin
        if (power_i === 1'b1 || !three_wire_i) begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1) lvl <= !lvl;
        end
    end
    // For an unpowered three-wire fan, the pull-up holds the line high.
    assign pulse_o = (three_wire_i && power_i !== 1'b1) ? 1'b1 : lvl;
endmodule
`default_nettype wire

// [tb/tb_fpdm_fan_pwm_drive_speed_meter.sv]
// Testbench for the fan drive and speed meter.
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
    num_errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_fpdm_fan_pwm_drive_speed_meter;
    timeunit 1ns;
    timeprecision 1ns;
    // Stimulus, results and counters.
    logic ref_clk_i = 1'b0, srst_i = 1'b1, high_rate_drive_i = 1'b1;
    logic [7:0] continuous_measure_enable_i = 8'h00;
    logic [31:0] duty_i = 32'h0;
    logic measure_req_i = 1'b0, three_wire = 1'b0;
    // Each fan model drives its own bit of the speed lines.
    wire [7:0] fan_speed_pulse_input_i;
    logic [7:0] speed_update_o;
    logic [7:0] continuous_measure_o, stalled_o;
    logic [3:0] fan_drive_o;
    logic [127:0] speed_value_o;
    int num_errors = 0, checks_done = 0;
    initial forever #50 ref_clk_i = !ref_clk_i;
    fpdm_fan_pwm_drive_speed_meter u_fpdm_fan_pwm_drive_speed_meter (
        .ref_clk_i, .srst_i, .high_rate_drive_i,
        .continuous_measure_enable_i, .duty_i, .measure_req_i,
        .fan_speed_pulse_input_i, .fan_drive_o, .speed_value_o,
        .speed_update_o, .continuous_measure_o, .stalled_o);
    // Fan n+4 shares drive n with fan n.
    for (genvar c = 0; c < 8; c++) begin : g_fan
        fpdm_fan_model u_fpdm_fan_model (.clk_i(ref_clk_i),
            .power_i(fan_drive_o[c % 4]), .three_wire_i(three_wire),
            .pulse_o(fan_speed_pulse_input_i[c]));
    end
    task automatic end_of_test();
        if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Waits, bounded, for a result on channel c.
    task automatic wait_upd(input int c);
        int n;
        n = 0;
        do begin
            @(negedge ref_clk_i);
            n++;
            if (n > 20000) begin
                num_errors++;
                end_of_test();
            end
        end while (speed_update_o[c] !== 1'b1);
    endtask
    // Two pulse periods of 1110 cycles are 20 ticks of 111 cycles.
    task automatic check_value(input int c);
        logic [15:0] v;
        v = speed_value_o[c*16 +: 16];
        `CHK(v >= 16'h0013 && v <= 16'h0015, 1'b1)
    endtask
    // Four-wire fans at the high rate are measured continuously.
    task automatic t_cont();
        @(negedge ref_clk_i);
        `CHK(continuous_measure_o, 8'hff)
        wait_upd(0);
        wait_upd(0);
        check_value(0);
        wait_upd(4);
        check_value(4);
        `CHK(stalled_o, 8'h00)
    endtask
    // Half duty gives half on-time at 22.5 kHz: 10 periods in 4440.
    task automatic t_duty();
        int hi, rises;
        logic last;
        hi = 0;
        rises = 0;
        last = 1'b0;
        @(posedge ref_clk_i);
        duty_i <= 32'h0000_0080;
        repeat (500) @(negedge ref_clk_i);
        repeat (4440) begin
            @(negedge ref_clk_i);
            hi += int'(fan_drive_o[0] === 1'b1);
            rises += int'(fan_drive_o[0] === 1'b1 && !last);
            last = fan_drive_o[0];
        end
        `CHK(hi >= 2180 && hi <= 2260, 1'b1)
        `CHK(rises >= 9 && rises <= 11, 1'b1)
    endtask
    // Unpowered three-wire fans only turn while the drive is stretched.
    task automatic t_stretch();
        @(posedge ref_clk_i);
        high_rate_drive_i <= 1'b0;
        duty_i <= 32'h0;
        three_wire <= 1'b1;
        srst_i <= 1'b1;
        @(posedge ref_clk_i);
        srst_i <= 1'b0;
        measure_req_i <= 1'b1;
        @(posedge ref_clk_i);
        measure_req_i <= 1'b0;
        repeat (50) @(negedge ref_clk_i);
        `CHK(fan_drive_o, 4'hf)
        wait_upd(0);
        check_value(0);
        // A continuous bit on both fans of drive 0 removes its stretch.
        @(posedge ref_clk_i);
        continuous_measure_enable_i <= 8'h11;
        measure_req_i <= 1'b1;
        @(posedge ref_clk_i);
        measure_req_i <= 1'b0;
        repeat (50) @(negedge ref_clk_i);
        `CHK(continuous_measure_o, 8'h11)
        `CHK(fan_drive_o, 4'he)
    endtask
    initial begin
        repeat (4) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        t_cont();
        t_duty();
        t_stretch();
        end_of_test();
    end
endmodule
bind fpdm_fan_pwm_drive_speed_meter fpdm_props u_fpdm_props (
    .ref_clk_i, .srst_i, .high_rate_drive_i,
    .continuous_measure_enable_i, .duty_i, .fan_speed_pulse_input_i,
    .fan_drive_o, .speed_value_o, .speed_update_o,
    .continuous_measure_o, .stalled_o);
`default_nettype wire
